/* rtl/pts_regs.vh */
// Constants of the processor trap sequencer: vectors, opcodes, status word
// fields and timing counts. Assumes a 10 MHz processor clock.
`ifndef PTS_REGS_VH
`define PTS_REGS_VH

// Trap vector pairs: new PC at base, new status word at base + 2
`define PTS_VEC_BPT 16'h000C
`define PTS_VEC_IOT 16'h0010
`define PTS_VEC_RSVD 16'h0008
`define PTS_VEC_BUSERR 16'h0004
`define PTS_VEC_PFAIL 16'h0014
`define PTS_WORD_BYTES 16'h0002

// Opcodes handled here
`define PTS_OP_HALT 16'h0000
`define PTS_OP_WAIT 16'h0001
`define PTS_OP_RTI 16'h0002
`define PTS_OP_BPT 16'h0003
`define PTS_OP_IOT 16'h0004
`define PTS_OP_RTT 16'h0006
`define PTS_OP_JMP 16'h0040
`define PTS_MASK_JMP 16'hFFC0
`define PTS_OP_JSR 16'h0800
`define PTS_MASK_JSR 16'hFE00
`define PTS_MODE_REG 3'h0

// Status word fields
`define PTS_PS_T 4
`define PTS_PS_PRIO_HI 7
`define PTS_PS_PRIO_LO 5

// Lowest legal stack address for traps
`define PTS_STACK_LIMIT 16'h0100

// Timing
`define PTS_CLK_NS 100
`define PTS_TIMEOUT_NS 10000
`define PTS_TIMEOUT_CYC 16'h0064
`define PTS_PFAIL_NS 2000000
`define PTS_PFAIL_CYC 16'h4E20

`endif

/* rtl/pts_bus_check.v */
// Bus reference checker: odd word address and no-response timeout.
// Assumes a requester holding req until ack, one clock, sync reset.
`timescale 1ns/10ps
`include "pts_regs.vh"

module pts_bus_check
(
    input wire clk,
    input wire rst_n,
    input wire req,
    input wire ack,
    input wire word,
    input wire [15:0] addr,
    output reg odd_err,
    output reg timeout_err
);

localparam [15:0] TO_CYC = `PTS_TIMEOUT_CYC;

reg [15:0] wait_cnt_reg;
reg odd_seen_reg;

always @(posedge clk)
begin
    if (!rst_n)
    begin
        wait_cnt_reg <= 16'h0000;
        odd_seen_reg <= 1'b0;
        odd_err <= 1'b0;
        timeout_err <= 1'b0;
    end
    else
    begin
        // One pulse per odd word reference
        odd_err <= req && word && addr[0] && !odd_seen_reg;
        odd_seen_reg <= req && word && addr[0];
        if (req && !ack)
            wait_cnt_reg <= wait_cnt_reg + 16'h0001;
        else
            wait_cnt_reg <= 16'h0000;
        timeout_err <= req && !ack && (wait_cnt_reg == TO_CYC - 16'h0001);
    end
end

endmodule

/* rtl/pts_trap_sequencer.v */
// Trap and return sequencer: stacks status word and PC, loads vectors,
// runs the two return instructions and arbitrates trace and fault traps.
// Assumes a datapath that waits for resume before each fetch and
// system bus memory that answers with ack.
//
`timescale 1ns/10ps
`include "pts_regs.vh"

// Function
// - Breakpoint pushes status, PC; vector 14
// - I/O trap same stacking; vector 20
// - Condition flags come from vector status
// - Interrupt return pops PC then status
// - Trap return inhibits trace at its end
// - Interrupt return restoring trace traps immediately
// - Reserved opcode vector 10, illegal vector 4
// - Register-mode jump or call is illegal
// - Odd word or fetch address is bus error
// - Bus timeout errors trap through vector 4; during trap stacking or vector reads they halt
// - Trace bit traps after next instruction
// - Trace flag latches at traced fetch
// - Instruction or bus trap beats trace
// - Traced overflow: trace first, then overflow
// - Interrupt before traced fetch served first
// - Traced wait traps immediately
// - Traced halt stops; trap after next
// - Traced trap return defers trace trap
// - Power failure traps via 24 and 26
// - Priority: odd, timeout, instruction, trace, overflow, power, interrupt
// - Priority seven vector status blocks interrupts
// - Stack moves through R6 by words
module pts_trap_sequencer
#(
    parameter [15:0] PF_CYC = `PTS_PFAIL_CYC
)
(
    input wire clk,
    input wire rst_n,
    input wire fetch_valid,
    input wire [15:0] instr_word,
    input wire reserved_op,
    input wire exec_done,
    input wire dp_req,
    input wire dp_ack,
    input wire dp_word,
    input wire [15:0] dp_addr,
    input wire dp_stk_ovf,
    input wire [15:0] ps_cur,
    input wire [15:0] pc_cur,
    input wire [15:0] sp_cur,
    input wire intr_req,
    input wire [2:0] intr_prio,
    input wire [15:0] intr_vec,
    input wire pwr_fail,
    input wire console_cont,
    output reg intr_ack,
    output reg bus_req,
    output reg bus_we,
    output reg [15:0] bus_addr,
    output reg [15:0] bus_wdata,
    input wire [15:0] bus_rdata,
    input wire bus_ack,
    output reg dp_abort,
    output reg resume,
    output reg pc_load,
    output reg [15:0] pc_new,
    output reg ps_load,
    output reg [15:0] ps_new,
    output reg sp_load,
    output reg [15:0] sp_new,
    output reg halted,
    output reg waiting,
    output reg pwr_down
);

// ****************************************
// States and instruction classes
// ****************************************
localparam [3:0] S_IDLE = 4'h0;
localparam [3:0] S_CHECK = 4'h1;
localparam [3:0] S_PUSH_PS = 4'h2;
localparam [3:0] S_PUSH_PC = 4'h3;
localparam [3:0] S_RD_PC = 4'h4;
localparam [3:0] S_RD_PS = 4'h5;
localparam [3:0] S_LOAD = 4'h6;
localparam [3:0] S_POP_PC = 4'h7;
localparam [3:0] S_POP_PS = 4'h8;
localparam [3:0] S_WAIT = 4'h9;
localparam [3:0] S_HALT = 4'hA;

localparam [2:0] C_NONE = 3'h0;
localparam [2:0] C_TRAP = 3'h1;
localparam [2:0] C_RTI = 3'h2;
localparam [2:0] C_RTT = 3'h3;
localparam [2:0] C_WAIT = 3'h4;
localparam [2:0] C_HALT = 3'h5;

reg [3:0] state_reg;
reg [2:0] cls_reg;
reg [15:0] cls_vec_reg;
reg trace_flag_reg;
reg trace_inhibit_reg;
reg ovf_pend_reg;
reg ovf_trap_reg;
reg pf_pend_reg;
reg pf_prev_reg;
reg pf_cnt_run_reg;
reg [15:0] pf_cnt_reg;
reg [15:0] sp_reg;
reg [15:0] vec_reg;
reg [15:0] ps_stk_reg;
reg [15:0] pc_stk_reg;
reg [15:0] pc_pop_reg;

wire dp_odd;
wire dp_timeout;
wire own_odd;
wire own_timeout;
wire own_err = own_odd || own_timeout;

// ****************************************
// Bus reference checks
// ****************************************
pts_bus_check u_dp_check
(
    .clk(clk),
    .rst_n(rst_n),
    .req(dp_req),
    .ack(dp_ack),
    .word(dp_word),
    .addr(dp_addr),
    .odd_err(dp_odd),
    .timeout_err(dp_timeout)
);

pts_bus_check u_own_check
(
    .clk(clk),
    .rst_n(rst_n),
    .req(bus_req),
    .ack(bus_ack),
    .word(1'b1),
    .addr(bus_addr),
    .odd_err(own_odd),
    .timeout_err(own_timeout)
);

// ****************************************
// Decode at fetch
// ****************************************
wire is_jmp_reg = ((instr_word & `PTS_MASK_JMP) == `PTS_OP_JMP) &&
    (instr_word[5:3] == `PTS_MODE_REG);
wire is_jsr_reg = ((instr_word & `PTS_MASK_JSR) == `PTS_OP_JSR) &&
    (instr_word[5:3] == `PTS_MODE_REG);
wire is_illegal = is_jmp_reg || is_jsr_reg;

wire intr_ok = intr_req && (intr_prio > ps_cur[`PTS_PS_PRIO_HI:`PTS_PS_PRIO_LO]);
wire push_low = (sp_reg - `PTS_WORD_BYTES) < `PTS_STACK_LIMIT;
wire [15:0] sp_dec = sp_reg - `PTS_WORD_BYTES;
wire [15:0] sp_inc = sp_reg + `PTS_WORD_BYTES;

// ****************************************
// Sequencer
// ****************************************
always @(posedge clk)
begin
    if (!rst_n)
    begin
        state_reg <= S_IDLE;
        cls_reg <= C_NONE;
        cls_vec_reg <= 16'h0000;
        trace_flag_reg <= 1'b0;
        trace_inhibit_reg <= 1'b0;
        ovf_pend_reg <= 1'b0;
        ovf_trap_reg <= 1'b0;
        pf_pend_reg <= 1'b0;
        pf_prev_reg <= 1'b0;
        pf_cnt_run_reg <= 1'b0;
        pf_cnt_reg <= 16'h0000;
        sp_reg <= 16'h0000;
        vec_reg <= 16'h0000;
        ps_stk_reg <= 16'h0000;
        pc_stk_reg <= 16'h0000;
        pc_pop_reg <= 16'h0000;
        intr_ack <= 1'b0;
        bus_req <= 1'b0;
        bus_we <= 1'b0;
        bus_addr <= 16'h0000;
        bus_wdata <= 16'h0000;
        dp_abort <= 1'b0;
        resume <= 1'b0;
        pc_load <= 1'b0;
        pc_new <= 16'h0000;
        ps_load <= 1'b0;
        ps_new <= 16'h0000;
        sp_load <= 1'b0;
        sp_new <= 16'h0000;
        halted <= 1'b0;
        waiting <= 1'b0;
        pwr_down <= 1'b0;
    end
    else
    begin
        intr_ack <= 1'b0;
        dp_abort <= 1'b0;
        resume <= 1'b0;
        pc_load <= 1'b0;
        ps_load <= 1'b0;
        sp_load <= 1'b0;
        pf_prev_reg <= pwr_fail;
        // Power fail edge pends until its trap is taken
        if (pwr_fail && !pf_prev_reg)
            pf_pend_reg <= 1'b1;
        // Shutdown window after the power fail trap
        if (pf_cnt_run_reg)
        begin
            if (pf_cnt_reg == PF_CYC - 16'h0001)
            begin
                pwr_down <= 1'b1;
                pf_cnt_run_reg <= 1'b0;
            end
            else
                pf_cnt_reg <= pf_cnt_reg + 16'h0001;
        end
        // A traced overflow is left for the trace stacking to meet again
        if (dp_stk_ovf && !trace_flag_reg)
            ovf_pend_reg <= 1'b1;
        case (state_reg)
        S_IDLE:
        begin
            sp_reg <= sp_cur;
            ps_stk_reg <= ps_cur;
            pc_stk_reg <= pc_cur;
            if (fetch_valid)
            begin
                trace_flag_reg <= ps_cur[`PTS_PS_T];
                cls_reg <= C_NONE;
                if (instr_word == `PTS_OP_BPT)
                begin
                    cls_reg <= C_TRAP;
                    cls_vec_reg <= `PTS_VEC_BPT;
                end
                else if (instr_word == `PTS_OP_IOT)
                begin
                    cls_reg <= C_TRAP;
                    cls_vec_reg <= `PTS_VEC_IOT;
                end
                else if (reserved_op)
                begin
                    cls_reg <= C_TRAP;
                    cls_vec_reg <= `PTS_VEC_RSVD;
                end
                else if (is_illegal)
                begin
                    cls_reg <= C_TRAP;
                    cls_vec_reg <= `PTS_VEC_BUSERR;
                end
                else if (instr_word == `PTS_OP_RTI)
                    cls_reg <= C_RTI;
                else if (instr_word == `PTS_OP_RTT)
                    cls_reg <= C_RTT;
                else if (instr_word == `PTS_OP_WAIT)
                    cls_reg <= C_WAIT;
                else if (instr_word == `PTS_OP_HALT)
                    cls_reg <= C_HALT;
            end
            if (dp_odd || dp_timeout)
            begin
                // Fault aborts the instruction; trace is dropped
                dp_abort <= 1'b1;
                trace_flag_reg <= 1'b0;
                vec_reg <= `PTS_VEC_BUSERR;
                ovf_trap_reg <= 1'b0;
                state_reg <= S_PUSH_PS;
            end
            else if (exec_done)
            begin
                if (cls_reg == C_TRAP)
                begin
                    trace_flag_reg <= 1'b0;
                    vec_reg <= cls_vec_reg;
                    ovf_trap_reg <= 1'b0;
                    state_reg <= S_PUSH_PS;
                end
                else if (cls_reg == C_RTI || cls_reg == C_RTT)
                    state_reg <= S_POP_PC;
                else if (cls_reg == C_HALT)
                begin
                    trace_flag_reg <= 1'b0;
                    halted <= 1'b1;
                    state_reg <= S_HALT;
                end
                else
                    state_reg <= S_CHECK;
            end
        end
        S_CHECK:
        begin
            // Boundary: trace, overflow, power fail, interrupt, wait
            trace_inhibit_reg <= 1'b0;
            // Values popped by a return reach the datapath only now
            ps_stk_reg <= ps_load ? ps_new : ps_cur;
            pc_stk_reg <= pc_load ? pc_new : pc_cur;
            sp_reg <= sp_load ? sp_new : sp_cur;
            ovf_trap_reg <= 1'b0;
            if (trace_flag_reg && !trace_inhibit_reg)
            begin
                trace_flag_reg <= 1'b0;
                vec_reg <= `PTS_VEC_BPT;
                state_reg <= S_PUSH_PS;
            end
            else if (ovf_pend_reg)
            begin
                ovf_pend_reg <= dp_stk_ovf && !trace_flag_reg;
                ovf_trap_reg <= 1'b1;
                vec_reg <= `PTS_VEC_BUSERR;
                state_reg <= S_PUSH_PS;
            end
            else if (pf_pend_reg && !(pwr_fail && !pf_prev_reg))
            begin
                pf_pend_reg <= 1'b0;
                pf_cnt_run_reg <= 1'b1;
                pf_cnt_reg <= 16'h0000;
                vec_reg <= `PTS_VEC_PFAIL;
                state_reg <= S_PUSH_PS;
            end
            else if (intr_ok)
            begin
                intr_ack <= 1'b1;
                vec_reg <= intr_vec;
                waiting <= 1'b0;
                state_reg <= S_PUSH_PS;
            end
            else if (cls_reg == C_WAIT)
            begin
                waiting <= 1'b1;
                state_reg <= S_WAIT;
            end
            else
            begin
                resume <= 1'b1;
                state_reg <= S_IDLE;
            end
        end
        S_WAIT:
        begin
            if (intr_ok || pf_pend_reg)
            begin
                cls_reg <= C_NONE;
                state_reg <= S_CHECK;
            end
        end
        S_HALT:
        begin
            if (console_cont)
            begin
                halted <= 1'b0;
                resume <= 1'b1;
                state_reg <= S_IDLE;
            end
        end
        S_PUSH_PS, S_PUSH_PC:
        begin
            if (own_err)
            begin
                bus_req <= 1'b0;
                halted <= 1'b1;
                state_reg <= S_HALT;
            end
            else if (!bus_req)
            begin
                bus_req <= 1'b1;
                bus_we <= 1'b1;
                bus_addr <= sp_dec;
                bus_wdata <= (state_reg == S_PUSH_PS) ? ps_stk_reg : pc_stk_reg;
                if (push_low && !ovf_trap_reg)
                    ovf_pend_reg <= 1'b1;
            end
            else if (bus_ack)
            begin
                bus_req <= 1'b0;
                sp_reg <= sp_dec;
                state_reg <= (state_reg == S_PUSH_PS) ? S_PUSH_PC : S_RD_PC;
            end
        end
        S_RD_PC, S_RD_PS:
        begin
            if (own_err)
            begin
                bus_req <= 1'b0;
                halted <= 1'b1;
                state_reg <= S_HALT;
            end
            else if (!bus_req)
            begin
                bus_req <= 1'b1;
                bus_we <= 1'b0;
                bus_addr <= (state_reg == S_RD_PC) ? vec_reg : vec_reg + `PTS_WORD_BYTES;
            end
            else if (bus_ack)
            begin
                bus_req <= 1'b0;
                if (state_reg == S_RD_PC)
                begin
                    pc_new <= bus_rdata;
                    state_reg <= S_RD_PS;
                end
                else
                begin
                    ps_new <= bus_rdata;
                    state_reg <= S_LOAD;
                end
            end
        end
        S_LOAD:
        begin
            pc_load <= 1'b1;
            ps_load <= 1'b1;
            sp_load <= 1'b1;
            sp_new <= sp_reg;
            cls_reg <= C_NONE;
            if (ovf_pend_reg && !ovf_trap_reg)
            begin
                // Overflow met while stacking: trap again from new state
                ovf_pend_reg <= dp_stk_ovf && !trace_flag_reg;
                ovf_trap_reg <= 1'b1;
                ps_stk_reg <= ps_new;
                pc_stk_reg <= pc_new;
                vec_reg <= `PTS_VEC_BUSERR;
                state_reg <= S_PUSH_PS;
            end
            else
            begin
                // Interrupts may be taken from the next boundary on
                resume <= 1'b1;
                state_reg <= S_IDLE;
            end
        end
        S_POP_PC, S_POP_PS:
        begin
            if (own_err)
            begin
                bus_req <= 1'b0;
                trace_flag_reg <= 1'b0;
                vec_reg <= `PTS_VEC_BUSERR;
                ovf_trap_reg <= 1'b0;
                state_reg <= S_PUSH_PS;
            end
            else if (!bus_req)
            begin
                bus_req <= 1'b1;
                bus_we <= 1'b0;
                bus_addr <= sp_reg;
            end
            else if (bus_ack)
            begin
                bus_req <= 1'b0;
                sp_reg <= sp_inc;
                if (state_reg == S_POP_PC)
                begin
                    pc_pop_reg <= bus_rdata;
                    state_reg <= S_POP_PS;
                end
                else
                begin
                    pc_new <= pc_pop_reg;
                    ps_new <= bus_rdata;
                    pc_load <= 1'b1;
                    ps_load <= 1'b1;
                    sp_load <= 1'b1;
                    sp_new <= sp_inc;
                    if (cls_reg == C_RTT)
                        trace_inhibit_reg <= 1'b1;
                    else if (bus_rdata[`PTS_PS_T])
                        trace_flag_reg <= 1'b1;
                    cls_reg <= C_NONE;
                    state_reg <= S_CHECK;
                end
            end
        end
        default:
        begin
            state_reg <= S_IDLE;
        end
        endcase
    end
end

endmodule

/* tb/pts_checker.sv */
// Checker of the trap sequencer ports: stacking, vectors, returns.
// Assumes a bind into pts_trap_sequencer; one clock, sync reset.
`timescale 1ns/10ps
module pts_checker
#(
    parameter [15:0] PF_CYC = 16'h0014
)
(
    input wire clk,
    input wire rst_n,
    input wire bus_req,
    input wire bus_we,
    input wire bus_ack,
    input wire [15:0] bus_addr,
    input wire [15:0] bus_wdata,
    input wire [15:0] bus_rdata,
    input wire [15:0] ps_cur,
    input wire [15:0] pc_cur,
    input wire [15:0] sp_cur,
    input wire pc_load,
    input wire ps_load,
    input wire [15:0] pc_new,
    input wire [15:0] ps_new,
    input wire [15:0] sp_new,
    input wire dp_abort,
    input wire intr_ack,
    input wire [2:0] intr_prio
);
default clocking cb @(posedge clk);
endclocking
default disable iff (!rst_n);
// ****************************************
// Helper logic
// ****************************************
reg wr_ph;
reg [15:0] vb, vpc, vps, pps;
wire rd_ack = bus_req && !bus_we && bus_ack;
wire vec_lo = rd_ack && bus_addr < 16'h0100 && !bus_addr[1];
wire vec_hi = rd_ack && bus_addr == vb + 16'h0002;
wire pop_pc = rd_ack && bus_addr == sp_cur && bus_addr >= 16'h0100;
wire pop_ps = rd_ack && bus_addr == sp_cur + 16'h0002 && bus_addr >= 16'h0100;
always @(posedge clk)
begin
    if (!rst_n)
    begin
        wr_ph <= 1'b0;
        vb <= 16'h0000;
        vpc <= 16'h0000;
        vps <= 16'h0000;
        pps <= 16'h0000;
    end
    else
    begin
        if (bus_req && bus_we && bus_ack)
            wr_ph <= ~wr_ph;
        if (vec_lo)
            vb <= bus_addr;
        if (vec_lo)
            vpc <= bus_rdata;
        if (vec_hi)
            vps <= bus_rdata;
        if (pop_ps)
            pps <= bus_rdata;
    end
end
sequence s_vec_lo;
    vec_lo;
endsequence
sequence s_vec_hi;
    vec_hi;
endsequence
sequence s_pop_pc;
    pop_pc;
endsequence
sequence s_pop_ps;
    pop_ps;
endsequence
// ****************************************
// Assertions
// ****************************************
a_req_hold: assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_addr)
    && $stable(bus_we) && $stable(bus_wdata)) else $error("bus request changed early");
a_first_push: assert property (bus_req && bus_we && !wr_ph |->
    bus_addr == sp_cur - 16'h0002 && bus_wdata == ps_cur) else $error("status push wrong");
a_second_push: assert property (bus_req && bus_we && wr_ph |->
    bus_addr == sp_cur - 16'h0004 && bus_wdata == pc_cur) else $error("pc push wrong");
a_vec_pair: assert property (s_vec_lo |=> ##[0:200] s_vec_hi)
    else $error("vector status word not read");
a_vec_load: assert property (s_vec_hi |-> ##[1:4] (pc_load && ps_load && pc_new == vpc
    && ps_new == vps && sp_new == sp_cur - 16'h0004)) else $error("vector load wrong");
a_pop_pair: assert property (s_pop_pc |=> ##[0:200] s_pop_ps)
    else $error("status pop missing");
a_pop_load: assert property (s_pop_ps |-> ##[1:4] (ps_load && ps_new == pps
    && sp_new == sp_cur + 16'h0004)) else $error("return load wrong");
a_abort_trap: assert property (dp_abort |-> ##[1:10] (bus_req && bus_we
    && bus_addr == sp_cur - 16'h0002)) else $error("fault did not trap");
a_intr_prio: assert property (intr_ack |-> $past(intr_prio) > $past(ps_cur[7:5]))
    else $error("interrupt taken at blocked priority");
endmodule

/* tb/pts_mem_model.sv */
// System bus memory: stack words and trap vectors, slow or prompt.
// Assumes bus_req held until the edge after bus_ack.
`timescale 1ns/10ps
module pts_mem_model
(
    input wire clk,
    input wire rst_n,
    input wire [3:0] lat,
    input wire bus_req,
    input wire bus_we,
    input wire [15:0] bus_addr,
    input wire [15:0] bus_wdata,
    output reg [15:0] bus_rdata,
    output reg bus_ack
);
reg [15:0] mem [0:32767];
reg [3:0] cnt;
integer i;
initial
begin
    for (i = 0; i < 32768; i = i + 1)
        mem[i] = {i[6:0], 1'b0, 8'h0F};
    bus_rdata = 16'h0000;
    bus_ack = 1'b0;
    cnt = 4'h0;
end
// Read data toggles outside the answer cycle
always @(posedge clk)
begin
    bus_rdata <= ~bus_rdata;
    bus_ack <= 1'b0;
    if (!rst_n)
        cnt <= 4'h0;
    else if (bus_req && !bus_ack)
    begin
        if (cnt >= lat)
        begin
            bus_ack <= 1'b1;
            cnt <= 4'h0;
            if (bus_we)
                mem[bus_addr[15:1]] <= bus_wdata;
            else
                bus_rdata <= mem[bus_addr[15:1]];
        end
        else
            cnt <= cnt + 4'h1;
    end
end
endmodule

/* tb/pts_trap_sequencer_test.sv */
// Testbench of the trap sequencer: plays the datapath, checks stacks
// and loads. Assumes the memory model and the checker bound below.
`timescale 1ns/10ps
module pts_trap_sequencer_test;
reg clk = 1'b0;
reg rst_n = 1'b0;
reg fetch_valid = 1'b0;
reg [15:0] instr_word = 16'h0000;
reg reserved_op = 1'b0;
reg exec_done = 1'b0;
reg dp_req = 1'b0;
reg dp_word = 1'b0;
reg [15:0] dp_addr = 16'h0000;
reg [15:0] ps_cur = 16'h0000;
reg [15:0] pc_cur = 16'h0200;
reg [15:0] sp_cur = 16'h0800;
reg intr_req = 1'b0;
reg [2:0] intr_prio = 3'h0;
reg [15:0] intr_vec = 16'h0040;
reg pwr_fail = 1'b0;
reg dp_stk_ovf = 1'b0;
reg [3:0] lat = 4'h0;
wire intr_ack, bus_req, bus_we, bus_ack, dp_abort, resume;
wire pc_load, ps_load, sp_load, halted, waiting, pwr_down;
wire [15:0] bus_addr, bus_wdata, bus_rdata, pc_new, ps_new, sp_new;
integer num_errors = 0;
integer checked = 0;
reg [15:0] ld_pc [0:7];
reg [15:0] ld_ps [0:7];
reg [15:0] ld_sp [0:7];
reg [2:0] nld = 3'h0;
reg [15:0] s, c, p;
always #50 clk = ~clk;
pts_trap_sequencer #(.PF_CYC(16'h0014)) u_dut (.clk(clk), .rst_n(rst_n),
    .fetch_valid(fetch_valid), .instr_word(instr_word), .reserved_op(reserved_op),
    .exec_done(exec_done), .dp_req(dp_req), .dp_ack(1'b0), .dp_word(dp_word),
    .dp_addr(dp_addr), .dp_stk_ovf(dp_stk_ovf), .ps_cur(ps_cur), .pc_cur(pc_cur),
    .sp_cur(sp_cur), .intr_req(intr_req), .intr_prio(intr_prio), .intr_vec(intr_vec),
    .pwr_fail(pwr_fail), .console_cont(1'b0), .intr_ack(intr_ack), .bus_req(bus_req),
    .bus_we(bus_we), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack), .dp_abort(dp_abort), .resume(resume), .pc_load(pc_load),
    .pc_new(pc_new), .ps_load(ps_load), .ps_new(ps_new), .sp_load(sp_load),
    .sp_new(sp_new), .halted(halted), .waiting(waiting), .pwr_down(pwr_down));
pts_mem_model u_mem (.clk(clk), .rst_n(rst_n), .lat(lat), .bus_req(bus_req),
    .bus_we(bus_we), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_ack(bus_ack));
// Datapath takes every load and logs it
always @(posedge clk)
begin
    if (pc_load)
    begin
        ld_pc[nld] <= pc_new;
        ld_ps[nld] <= ps_new;
        ld_sp[nld] <= sp_new;
        nld <= nld + 3'h1;
        pc_cur <= pc_new;
        ps_cur <= ps_new;
        sp_cur <= sp_new;
    end
end
// ****************************************
// Tasks
// ****************************************
task chk(input [15:0] got, input [15:0] exp);
begin
    checked = checked + 1;
    if (got !== exp)
    begin
        num_errors = num_errors + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
end
endtask
task conclude;
begin
    $display("Checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
end
endtask
task snap;
begin
    s = sp_cur;
    c = pc_cur;
    p = ps_cur;
    nld = 3'h0;
end
endtask
task wait_resume;
    integer n;
    reg rel;
begin
    n = 0;
    rel = 1'b0;
    while (n < 600)
    begin
        @(posedge clk);
        if (rel)
        begin
            dp_req <= 1'b0;
            intr_req <= 1'b0;
        end
        #1;
        rel = dp_abort | intr_ack;
        n = resume ? 1000 : n + 1;
    end
    if (n == 600)
        chk(16'h0000, 16'h0001);
    @(posedge clk);
    #1;
end
endtask
task run(input [15:0] op, input rsv, input [15:0] psx);
begin
    @(posedge clk);
    fetch_valid <= 1'b1;
    instr_word <= op;
    reserved_op <= rsv;
    @(posedge clk);
    fetch_valid <= 1'b0;
    reserved_op <= 1'b0;
    dp_stk_ovf <= 1'b0;
    exec_done <= 1'b1;
    ps_cur <= psx;
    @(posedge clk);
    exec_done <= 1'b0;
    wait_resume;
end
endtask
task trap_chk(input [15:0] v, input [15:0] s0, input [15:0] p0, input [15:0] c0);
begin
    chk(u_mem.mem[(s0 - 16'h0002) >> 1], p0);
    chk(u_mem.mem[(s0 - 16'h0004) >> 1], c0);
    chk(ld_pc[nld - 3'h1], {v[7:0], 8'h0F});
    chk(ld_ps[nld - 3'h1], {v[7:0] + 8'h02, 8'h0F});
    chk(ld_sp[nld - 3'h1], s0 - 16'h0004);
end
endtask
task trap_test(input [15:0] op, input rsv, input [15:0] psx, input [15:0] v);
begin
    snap;
    run(op, rsv, psx);
    trap_chk(v, s, psx, c);
end
endtask
task ret(input [15:0] op);
begin
    snap;
    u_mem.mem[s >> 1] = 16'h0300;
    u_mem.mem[(s + 16'h0002) >> 1] = 16'h0010;
    run(op, 1'b0, p);
end
endtask
task dp_fault(input [15:0] a);
begin
    snap;
    @(posedge clk);
    dp_req <= 1'b1;
    dp_word <= 1'b1;
    dp_addr <= a;
    wait_resume;
    trap_chk(16'h0004, s, p, c);
end
endtask
// ****************************************
// Main sequence
// ****************************************
initial
begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    trap_test(16'h0003, 1'b0, ps_cur, 16'h000C);
    lat <= 4'h3;
    trap_test(16'h0004, 1'b0, ps_cur, 16'h0010);
    trap_test(16'h0007, 1'b1, ps_cur, 16'h0008);
    trap_test(16'h0041, 1'b0, ps_cur, 16'h0004);
    trap_test(16'h0801, 1'b0, ps_cur, 16'h0004);
    @(posedge clk);
    ps_cur <= 16'h0010;
    trap_test(16'h00A0, 1'b0, 16'h0000, 16'h000C);
    ret(16'h0002);
    chk(ld_pc[0], 16'h0300);
    chk(ld_ps[0], 16'h0010);
    chk(ld_sp[0], s + 16'h0004);
    chk({13'h0, nld}, 16'h0002);
    trap_chk(16'h000C, s + 16'h0004, 16'h0010, 16'h0300);
    ret(16'h0006);
    chk({13'h0, nld}, 16'h0001);
    chk(ld_ps[0], 16'h0010);
    trap_test(16'h00A0, 1'b0, 16'h0010, 16'h000C);
    ps_cur <= 16'h0010;
    trap_test(16'h0001, 1'b0, 16'h0010, 16'h000C);
    dp_fault(16'h0201);
    dp_fault(16'h0200);
    snap;
    dp_stk_ovf <= 1'b1;
    run(16'h00A0, 1'b0, p);
    trap_chk(16'h0004, s, p, c);
    snap;
    intr_prio <= 3'h4;
    intr_req <= 1'b1;
    run(16'h00A0, 1'b0, 16'h00E0);
    chk({13'h0, nld}, 16'h0000);
    run(16'h00A0, 1'b0, 16'h0000);
    trap_chk(16'h0040, s, 16'h0000, c);
    snap;
    pwr_fail <= 1'b1;
    run(16'h00A0, 1'b0, p);
    trap_chk(16'h0014, s, p, c);
    repeat (60) @(posedge clk);
    #1;
    chk({15'h0, pwr_down}, 16'h0001);
    conclude;
end
initial
begin
    repeat (20000) @(posedge clk);
    num_errors = num_errors + 1;
    conclude;
end
endmodule
bind pts_trap_sequencer pts_checker #(.PF_CYC(PF_CYC)) u_chk (.clk(clk), .rst_n(rst_n),
    .bus_req(bus_req), .bus_we(bus_we), .bus_ack(bus_ack), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .ps_cur(ps_cur), .pc_cur(pc_cur),
    .sp_cur(sp_cur), .pc_load(pc_load), .ps_load(ps_load), .pc_new(pc_new),
    .ps_new(ps_new), .sp_new(sp_new), .dp_abort(dp_abort), .intr_ack(intr_ack),
    .intr_prio(intr_prio));
